// ---- hbcfg_chk_assertions.sv ----
// port assertions for the bridge config header
`timescale 1ns/1ns
module hbcfg_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic err_condition,
    input wire logic master_abort_cpl,
    input wire logic target_abort_cpl,
    input wire logic serr_message,
    input wire logic system_error_message_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence rd_at(logic [7:0] a);
        cfg_rd && cfg_addr == a;
    endsequence
    // ==========
    // output checks
    msg_sent_a: assert property (err_condition
        && system_error_message_enable |=> serr_message)
        else $error("message missing");
    rvalid_follows_a: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read valid missing");
    port_quiet_a: assert property (!cfg_rd
        |=> !cfg_rvalid && cfg_rdata == 8'h00) else $error("port not quiet");
    syserr_flag_a: assert property (serr_message ##1 rd_at(8'h07)
        |=> cfg_rdata[6]) else $error("system error flag");
    mabort_flag_a: assert property (master_abort_cpl ##1 rd_at(8'h07)
        |=> cfg_rdata[5]) else $error("master abort flag");
    tabort_flag_a: assert property (target_abort_cpl ##1 rd_at(8'h07)
        |=> cfg_rdata[4]) else $error("target abort flag");
    msg_gated_a: assert property (!system_error_message_enable
        |=> !serr_message) else $error("message while disabled");
    status_low_a: assert property (rd_at(8'h06)
        |=> cfg_rvalid && cfg_rdata == 8'h90) else $error("status low");
    status_fixed_a: assert property (rd_at(8'h07)
        |=> (cfg_rdata & 8'h8f) == 8'h00) else $error("status high");
    sub_class_a: assert property (rd_at(8'h0a)
        |=> cfg_rdata == 8'h00) else $error("sub class");
    base_class_a: assert property (rd_at(8'h0b)
        |=> cfg_rdata == 8'h06) else $error("base class");
    latency_zero_a: assert property (rd_at(8'h0d)
        |=> cfg_rdata == 8'h00) else $error("latency");
    header_zero_a: assert property (rd_at(8'h0e)
        |=> cfg_rdata == 8'h00) else $error("header");
    cover property (serr_message);
    cover property (err_condition && !system_error_message_enable);
    cover property (rd_at(8'h07) ##1 cfg_rdata != 8'h00);
endmodule
bind hbcfg_top hbcfg_chk u_hbcfg_chk (.clk(clk), .rst_n(rst_n),
    .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .err_condition(err_condition),
    .master_abort_cpl(master_abort_cpl),
    .target_abort_cpl(target_abort_cpl),
    .serr_message(serr_message),
    .system_error_message_enable(system_error_message_enable));

// ---- hbcfg_flag.sv ----
// sticky status flag, cleared by a write of one, set wins
`timescale 1ns/1ns
module hbcfg_flag
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clear,
    output logic flag
);

    // =========================================================
    // flag storage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag <= 1'b0;
        else if (set)
            flag <= 1'b1;
        else if (clear)
            flag <= 1'b0;
    end

endmodule

// ---- hbcfg_hub.sv ----
// hub side model raising event pulses on request
`timescale 1ns/1ns
module hbcfg_hub
(
    input wire logic clk,
    input wire logic [2:0] kick,
    output logic [2:0] evt
);
    always_ff @(posedge clk)
        evt <= kick;
endmodule

// ---- hbcfg_pkg.sv ----
// types shared by the bridge config header files
package hbcfg_pkg;
    typedef logic [7:0] hbcfg_byte_type;
    typedef enum logic [1:0]
    {
        HBCFG_FLAG_TABORT,
        HBCFG_FLAG_MABORT,
        HBCFG_FLAG_SYSERR
    } hbcfg_flag_type;
endpackage

// ---- hbcfg_regs.svh ----
// offsets, field positions and reset values of the bridge config header
`ifndef HBCFG_REGS_SVH
`define HBCFG_REGS_SVH

// =============================================================
// byte offsets in configuration space
`define HBCFG_OFF_CMD_LO 8'h04
`define HBCFG_OFF_CMD_HI 8'h05
`define HBCFG_OFF_STS_LO 8'h06
`define HBCFG_OFF_STS_HI 8'h07
`define HBCFG_OFF_REV 8'h08
`define HBCFG_OFF_SUB_CLASS 8'h0a
`define HBCFG_OFF_BASE_CLASS 8'h0b
`define HBCFG_OFF_LAT 8'h0d
`define HBCFG_OFF_LAYOUT 8'h0e
`define HBCFG_OFF_CAP_PTR 8'h34

// =============================================================
// bridge_status fields
`define HBCFG_STS_RESET 16'h0090
`define HBCFG_STS_SYSERR_BIT 14
`define HBCFG_STS_MABORT_BIT 13
`define HBCFG_STS_TABORT_BIT 12
`define HBCFG_STS_B2B_BIT 7
`define HBCFG_STS_CAPLIST_BIT 4
`define HBCFG_STS_FIXED 16'h0090

// =============================================================
// bridge_command fields
`define HBCFG_CMD_LO_FIXED 8'h06
`define HBCFG_CMD_ERRMSG_EN_BIT 8

// =============================================================
// fixed byte values and flag count
`define HBCFG_SUB_CLASS_VALUE 8'h00
`define HBCFG_BASE_CLASS_VALUE 8'h06
`define HBCFG_LAT_VALUE 8'h00
`define HBCFG_LAYOUT_VALUE 8'h00
`define HBCFG_CAP_PTR_RESET 8'h00
`define HBCFG_NUM_FLAGS 3

`endif

// ---- hbcfg_top.sv ----
// configuration header registers of the host bridge, function 0
//
// What this block does
// - sent error message sets status bit 14
// - bit 14 clears only by writing one
// - master abort completion sets bit 13
// - target abort completion sets bit 12
// - bits 15, 11, 8 read zero
// - select timing bits 10:9 read 00
// - bit 7 reads one, fast back-to-back
// - bit 4 reads one, list at 34h
// - status resets to 0090h
// - only enabled errors set bit 14
// - revision byte read only
// - sub-class byte reads 00h
// - base class byte reads 06h
// - latency timer reads zero, ignores writes
// - header type reads zero, no storage
// - command bit 8 enables error messages
//
// config port carries one byte per strobe, low byte at even offset
// read data stand one cycle after the strobe, 00 otherwise
// read and write in one cycle: the read sees the old value
// writes to read-only offsets and bits fall away silently
// error message leaves one cycle after an enabled condition
// system error flag lands one cycle after the message
// abort flags land one cycle after their completion
// status flags: event sets, write of one clears, set wins
// command low byte is fixed at 06h
// command high byte bit 0 is the error message enable
// revision and capability pointer come from parameters
`include "hbcfg_regs.svh"
`timescale 1ns/1ns
module hbcfg_top
#(
    // revision code value is arbitrary
    parameter logic [7:0] REVISION_CODE = 8'h01,
    parameter logic [7:0] CAPABILITY_OFFSET = 8'ha0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic err_condition,
    input wire logic master_abort_cpl,
    input wire logic target_abort_cpl,
    output logic serr_message,
    output logic system_error_message_enable
);

    // =========================================================
    // declarations
    // address hits
    logic hit_cmd_lo;
    logic hit_cmd_hi;
    logic hit_sts_lo;
    logic hit_sts_hi;
    logic hit_rev;
    logic hit_sub_class;
    logic hit_base_class;
    logic hit_lat;
    logic hit_layout;
    logic hit_cap_ptr;

    // write strobes
    logic wr_cmd_hi;
    logic wr_sts_hi;

    // flag vectors, indexed by flag type
    logic [`HBCFG_NUM_FLAGS-1:0] flag_set;
    logic [`HBCFG_NUM_FLAGS-1:0] flag_clear;
    logic [`HBCFG_NUM_FLAGS-1:0] flag_value;

    // register images and read path
    logic [15:0] bridge_status;
    logic [15:0] bridge_command;
    hbcfg_pkg::hbcfg_byte_type next_rdata;

    // =========================================================
    // address match
    always_comb
    begin
        hit_cmd_lo = 1'b0;
        hit_cmd_hi = 1'b0;
        hit_sts_lo = 1'b0;
        hit_sts_hi = 1'b0;
        hit_rev = 1'b0;
        hit_sub_class = 1'b0;
        hit_base_class = 1'b0;
        hit_lat = 1'b0;
        hit_layout = 1'b0;
        hit_cap_ptr = 1'b0;
        // command bytes
        if (cfg_addr == `HBCFG_OFF_CMD_LO)
        begin
            hit_cmd_lo = 1'b1;
        end
        else if (cfg_addr == `HBCFG_OFF_CMD_HI)
        begin
            hit_cmd_hi = 1'b1;
        end
        // status bytes
        else if (cfg_addr == `HBCFG_OFF_STS_LO)
        begin
            hit_sts_lo = 1'b1;
        end
        else if (cfg_addr == `HBCFG_OFF_STS_HI)
        begin
            hit_sts_hi = 1'b1;
        end
        // identity and class bytes
        else if (cfg_addr == `HBCFG_OFF_REV)
        begin
            hit_rev = 1'b1;
        end
        else if (cfg_addr == `HBCFG_OFF_SUB_CLASS)
        begin
            hit_sub_class = 1'b1;
        end
        else if (cfg_addr == `HBCFG_OFF_BASE_CLASS)
        begin
            hit_base_class = 1'b1;
        end
        // fixed bytes
        else if (cfg_addr == `HBCFG_OFF_LAT)
        begin
            hit_lat = 1'b1;
        end
        else if (cfg_addr == `HBCFG_OFF_LAYOUT)
        begin
            hit_layout = 1'b1;
        end
        else if (cfg_addr == `HBCFG_OFF_CAP_PTR)
        begin
            hit_cap_ptr = 1'b1;
        end
    end

    // =========================================================
    // write strobes
    always_comb
    begin
        wr_cmd_hi = cfg_wr && hit_cmd_hi;
        wr_sts_hi = cfg_wr && hit_sts_hi;
    end

    // =========================================================
    // command enable bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_error_message_enable <= 1'b0;
        end
        else if (wr_cmd_hi)
        begin
            system_error_message_enable <=
                cfg_wdata[`HBCFG_CMD_ERRMSG_EN_BIT-8];
        end
    end

    // =========================================================
    // error message toward the hub
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serr_message <= 1'b0;
        end
        // message gated by enable
        // one pulse per enabled condition cycle
        else
        begin
            serr_message <= err_condition && system_error_message_enable;
        end
    end

    // =========================================================
    // flag set events
    always_comb
    begin
        flag_set[hbcfg_pkg::HBCFG_FLAG_SYSERR] = serr_message;
        flag_set[hbcfg_pkg::HBCFG_FLAG_MABORT] = master_abort_cpl;
        flag_set[hbcfg_pkg::HBCFG_FLAG_TABORT] = target_abort_cpl;
    end

    // =========================================================
    // flag clears by writing one
    always_comb
    begin
        flag_clear[hbcfg_pkg::HBCFG_FLAG_SYSERR] =
            wr_sts_hi && cfg_wdata[`HBCFG_STS_SYSERR_BIT-8];
        flag_clear[hbcfg_pkg::HBCFG_FLAG_MABORT] =
            wr_sts_hi && cfg_wdata[`HBCFG_STS_MABORT_BIT-8];
        flag_clear[hbcfg_pkg::HBCFG_FLAG_TABORT] =
            wr_sts_hi && cfg_wdata[`HBCFG_STS_TABORT_BIT-8];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `HBCFG_NUM_FLAGS; gi = gi + 1)
        begin : g_flag
            hbcfg_flag u_flag
            (
                .clk(clk),
                .rst_n(rst_n),
                .set(flag_set[gi]),
                .clear(flag_clear[gi]),
                .flag(flag_value[gi])
            );
        end
    endgenerate

    // =========================================================
    // status image
    always_comb
    begin
        bridge_status = `HBCFG_STS_FIXED;
        // flag bits from the sticky flags
        bridge_status[`HBCFG_STS_SYSERR_BIT] =
            flag_value[hbcfg_pkg::HBCFG_FLAG_SYSERR];
        bridge_status[`HBCFG_STS_MABORT_BIT] =
            flag_value[hbcfg_pkg::HBCFG_FLAG_MABORT];
        bridge_status[`HBCFG_STS_TABORT_BIT] =
            flag_value[hbcfg_pkg::HBCFG_FLAG_TABORT];
    end

    // =========================================================
    // command image
    always_comb
    begin
        bridge_command = {8'h00, `HBCFG_CMD_LO_FIXED};
        bridge_command[`HBCFG_CMD_ERRMSG_EN_BIT] =
            system_error_message_enable;
    end

    // =========================================================
    // read mux, unmapped offsets read 00
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit_cmd_lo)
        begin
            next_rdata = bridge_command[7:0];
        end
        else if (hit_cmd_hi)
        begin
            next_rdata = bridge_command[15:8];
        end
        else if (hit_sts_lo)
        begin
            next_rdata = bridge_status[7:0];
        end
        else if (hit_sts_hi)
        begin
            next_rdata = bridge_status[15:8];
        end
        else if (hit_rev)
        begin
            next_rdata = REVISION_CODE;
        end
        else if (hit_sub_class)
        begin
            next_rdata = `HBCFG_SUB_CLASS_VALUE;
        end
        else if (hit_base_class)
        begin
            next_rdata = `HBCFG_BASE_CLASS_VALUE;
        end
        else if (hit_lat)
        begin
            next_rdata = `HBCFG_LAT_VALUE;
        end
        else if (hit_layout)
        begin
            next_rdata = `HBCFG_LAYOUT_VALUE;
        end
        else if (hit_cap_ptr)
        begin
            next_rdata = CAPABILITY_OFFSET;
        end
    end

    // =========================================================
    // read valid pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= cfg_rd;
        end
    end

    // =========================================================
    // read data, 00 between reads keeps port quiet
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rdata <= 8'h00;
        end
        else if (cfg_rd)
        begin
            cfg_rdata <= next_rdata;
        end
        else
        begin
            cfg_rdata <= 8'h00;
        end
    end

endmodule

// ---- hbcfg_top_bench.sv ----
// self-checking bench for the bridge config header
`timescale 1ns/1ns
module hbcfg_top_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cfg_wr = 1'h0;
    logic cfg_rd = 1'h0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [2:0] kick = 3'h0;
    logic [2:0] evt;
    logic [7:0] cfg_rdata;
    logic cfg_rvalid;
    logic serr_message;
    logic system_error_message_enable;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] offs [8] = '{8'h06, 8'h07, 8'h08, 8'h0a,
        8'h0b, 8'h0d, 8'h0e, 8'h34};
    logic [7:0] vals [8] = '{8'h90, 8'h00, 8'h5a, 8'h00,
        8'h06, 8'h00, 8'h00, 8'h40};
    always #25 clk = ~clk;
    // revision 5a is arbitrary
    hbcfg_top #(.REVISION_CODE(8'h5a), .CAPABILITY_OFFSET(8'h40))
    u_hbcfg_top (.clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .err_condition(evt[2]),
        .master_abort_cpl(evt[1]), .target_abort_cpl(evt[0]),
        .serr_message(serr_message),
        .system_error_message_enable(system_error_message_enable));
    hbcfg_hub u_hbcfg_hub (.clk(clk), .kick(kick), .evt(evt));
    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(logic [7:0] a, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH rdata at %h expected %h seen %h", a, exp, got);
        end
    endtask
    task automatic cmp_bit(string n, logic exp, logic got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", n, exp, got);
        end
    endtask
    task automatic chk(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        cfg_rd <= 1'h1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'h0;
        #1;
        cmp_bit("cfg_rvalid", 1'b1, cfg_rvalid);
        cmp(a, exp, cfg_rdata);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'h1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'h0;
    endtask
    // pulse one hub event, then let the flag land
    task automatic ev(int i, logic m);
        @(posedge clk);
        kick <= 3'h1 << i;
        @(posedge clk);
        kick <= 3'h0;
        @(posedge clk);
        #1;
        cmp_bit("serr_message", m, serr_message);
        repeat (2) @(posedge clk);
    endtask
    // abort event and clearing write meet at one edge
    task automatic t_collide();
        @(posedge clk);
        kick <= 3'h2;
        @(posedge clk);
        kick <= 3'h0;
        cfg_wr <= 1'h1;
        cfg_addr <= 8'h07;
        cfg_wdata <= 8'h20;
        @(posedge clk);
        cfg_wr <= 1'h0;
        repeat (2) @(posedge clk);
        chk(8'h07, 8'h20);
        wr(8'h07, 8'h20);
        chk(8'h07, 8'h00);
    endtask
    // reset in mid-run returns the reset image
    task automatic t_reset();
        ev(1, 1'b0);
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        chk(8'h07, 8'h00);
        chk(8'h05, 8'h00);
        chk(8'h06, 8'h90);
    endtask
    task automatic t_fixed();
        foreach (offs[i])
            chk(offs[i], vals[i]);
        chk(8'h04, 8'h06);
        chk(8'h20, 8'h00);
    endtask
    task automatic t_ro_write();
        for (int i = 0; i < 7; i++)
            wr(offs[i], 8'hff);
        t_fixed();
    endtask
    task automatic t_serr();
        ev(2, 1'b0);
        chk(8'h07, 8'h00);
        wr(8'h05, 8'h01);
        #1;
        cmp_bit("enable", 1'b1, system_error_message_enable);
        chk(8'h05, 8'h01);
        ev(2, 1'b1);
        chk(8'h07, 8'h40);
        wr(8'h07, 8'h00);
        chk(8'h07, 8'h40);
        wr(8'h07, 8'h40);
        chk(8'h07, 8'h00);
    endtask
    task automatic t_abort();
        ev(1, 1'b0);
        chk(8'h07, 8'h20);
        ev(0, 1'b0);
        chk(8'h07, 8'h30);
        wr(8'h07, 8'h20);
        chk(8'h07, 8'h10);
        wr(8'h07, 8'h10);
        chk(8'h07, 8'h00);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        t_fixed();
        t_ro_write();
        t_serr();
        t_abort();
        t_collide();
        t_reset();
        results();
    end
endmodule
